// file: rtl/npc_pins.v
// Pin function selection, general-purpose ports and chip-select five timing setup.
//
// Behaviour
// - A set direction bit makes the port pin an output.
// - In-use bit set gives general-purpose I/O; clear gives primary function.
// - Pins below 16 take data output when low config field is b11.
// - Pins 16 and above take data output when high config field is b11.
// - A clear direction bit makes the pin an input; ready/busy read so.
// - Chip selects 5 and 4 reach port A 23:22 with dir set, in-use and alt clear.
// - Function mux bit 1 clear routes chip-select 3, else second SDRAM select.
// - Function mux bit 0 clear routes chip-select 2, else first SDRAM select.
// - Chip select is enabled by its bit and set 8-bit or 16-bit wide.
// - Chip-select 5 wait-state count held in high word bits 45:40.
// - Read strobe assert delay at 31:28, negate delay at 27:24.
// - Byte strobe control bit 11 governs byte strobe behaviour.
// - Byte strobe 3 is write strobe for 8-bit, byte strobe 2 for 16-bit.
// - Command latch on port A 1, address latch on A 2, busy on B 16.
// - Card chip enable is chip-select 5 ANDed with ready/busy; the code also holds it high while the chip-select five enable bit is clear.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "npc_defs.vh"

module npc_pins (
  // Clock and reset.
  input wire CLOCK,
  input wire RST,
  // Register port.
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // Port A pins.
  input wire [31:0] PA_IN,
  output reg [31:0] PA_OUT,
  output reg [31:0] PA_OE,
  // Port B pins.
  input wire [31:0] PB_IN,
  output reg [31:0] PB_OUT,
  output reg [31:0] PB_OE,
  // Memory controller chip selects and SDRAM selects, active low.
  input wire [5:0] CS_N_IN,
  input wire SDRAM_SEL0_N,
  input wire SDRAM_SEL1_N,
  output reg CS2_PIN_N,
  output reg CS3_PIN_N,
  // Chip-select five setup seen by the memory controller.
  output reg CS5_ENABLE,
  output reg CS5_WIDE,
  output reg [5:0] CS5_WAIT_STATES,
  output reg [3:0] CS5_RD_ASSERT,
  output reg [3:0] CS5_RD_NEGATE,
  output reg CS5_BYTE_CTRL,
  output reg [3:0] CS5_WR_STROBE_SEL,
  // Flash card chip enable, active low.
  output reg CARD_CE_N
);

  // Port A configuration and data registers.
  reg [31:0] a_dir_reg;
  reg [31:0] a_gio_reg;
  reg [31:0] a_alt_reg;
  reg [31:0] a_ocl_reg;
  reg [31:0] a_och_reg;
  reg [31:0] a_dat_reg;
  // Port B registers; port B has no alternate-function select here.
  reg [31:0] b_dir_reg;
  reg [31:0] b_gio_reg;
  reg [31:0] b_ocl_reg;
  reg [31:0] b_och_reg;
  reg [31:0] b_dat_reg;
  // Function mux and chip-select five control words.
  reg [31:0] fmux_reg;
  reg [31:0] cs5h_reg;
  reg [31:0] cs5l_reg;
  // Next values of the registered outputs.
  reg [31:0] pa_next;
  reg [31:0] pb_next;
  reg [31:0] pa_oe_next;
  reg [31:0] pb_oe_next;
  reg [31:0] rdata_next;
  reg cs2_next;
  reg cs3_next;
  reg card_ce_next;
  // Card enable terms, both active high.
  wire cs5_asserted;
  wire card_busy;
  // Loop index of the pin drive process.
  integer i;

  // Output-source field test for pin n, shared by both ports.
  function src_is_data;
    input [31:0] ocl;
    input [31:0] och;
    input integer n;
    reg [1:0] f;
    begin
      // low config for pins below 16
      if (n < `NPC_OCR_SPLIT) begin
        f = {ocl[2*n+1], ocl[2*n]};
      end else begin
        f = {och[2*n-31], och[2*n-32]};
      end
      src_is_data = (f == `NPC_SRC_DATA);
    end
  endfunction

  // General-purpose output test for pin n of either port: in use, set as an
  // output and fed by the data register.
  function gpio_drives;
    input [31:0] gio;
    input [31:0] dir;
    input [31:0] ocl;
    input [31:0] och;
    input integer n;
    begin
      gpio_drives = gio[n] & dir[n] & src_is_data(ocl, och, n);
    end
  endfunction

  // Write strobe lane for the port width. The lane is one-hot so that the
  // controller can use it directly as a byte strobe mask.
  function [3:0] strobe_lane;
    input wide;
    begin
      if (wide) begin
        strobe_lane = `NPC_LANE_16BIT;
      end else begin
        strobe_lane = `NPC_LANE_8BIT;
      end
    end
  endfunction

  // Register writes; latch-enable data bits reset low so both latches idle.
  always @(posedge CLOCK) begin
    if (RST) begin
      a_dir_reg <= `NPC_RST_ZERO;
      a_gio_reg <= `NPC_RST_ZERO;
      a_alt_reg <= `NPC_RST_ZERO;
      a_ocl_reg <= `NPC_RST_ZERO;
      a_och_reg <= `NPC_RST_ZERO;
      a_dat_reg <= `NPC_RST_ZERO;
      b_dir_reg <= `NPC_RST_ZERO;
      b_gio_reg <= `NPC_RST_ZERO;
      b_ocl_reg <= `NPC_RST_ZERO;
      b_och_reg <= `NPC_RST_ZERO;
      b_dat_reg <= `NPC_RST_ZERO;
      fmux_reg <= `NPC_RST_FMUX;
      cs5h_reg <= `NPC_RST_ZERO;
      cs5l_reg <= `NPC_RST_ZERO;
    // Writes to unmapped offsets fall through and change nothing.
    end else if (WR) begin
      case (ADDR)
        `NPC_OFF_A_DIR: a_dir_reg <= WDATA;
        `NPC_OFF_A_GIO: a_gio_reg <= WDATA;
        `NPC_OFF_A_ALT: a_alt_reg <= WDATA;
        `NPC_OFF_A_OCL: a_ocl_reg <= WDATA;
        `NPC_OFF_A_OCH: a_och_reg <= WDATA;
        `NPC_OFF_A_DAT: a_dat_reg <= WDATA;
        `NPC_OFF_B_DIR: b_dir_reg <= WDATA;
        `NPC_OFF_B_GIO: b_gio_reg <= WDATA;
        `NPC_OFF_B_OCL: b_ocl_reg <= WDATA;
        `NPC_OFF_B_OCH: b_och_reg <= WDATA;
        `NPC_OFF_B_DAT: b_dat_reg <= WDATA;
        `NPC_OFF_FMUX: fmux_reg <= WDATA;
        `NPC_OFF_CS5H: cs5h_reg <= WDATA;
        `NPC_OFF_CS5L: cs5l_reg <= WDATA;
        default: ;
      endcase
    end
  end

  // Pin drive per bit. A general-purpose output whose source is not the
  // data register is left undriven, since no other source exists here.
  always @* begin
    pa_next = 32'h00000000;
    pa_oe_next = 32'h00000000;
    pb_next = 32'h00000000;
    pb_oe_next = 32'h00000000;
    for (i = 0; i < 32; i = i + 1) begin
      if (a_gio_reg[i]) begin
        pa_oe_next[i] = gpio_drives(a_gio_reg, a_dir_reg, a_ocl_reg, a_och_reg, i);
        pa_next[i] = a_dat_reg[i];
      end else if (a_dir_reg[i] & ~a_alt_reg[i]) begin
        // Primary-function pins with no source of their own idle high.
        pa_oe_next[i] = 1'b1;
        pa_next[i] = 1'b1;
      end
      // Port B pins outside general-purpose use have no primary function here.
      if (b_gio_reg[i]) begin
        pb_oe_next[i] = gpio_drives(b_gio_reg, b_dir_reg, b_ocl_reg, b_och_reg, i);
        pb_next[i] = b_dat_reg[i];
      end
    end
    // The chip selects reach the pins only while their direction bits are set.
    // primary chip selects on A 23:22
    if (~a_gio_reg[`NPC_PIN_CS5] & ~a_alt_reg[`NPC_PIN_CS5]) begin
      pa_next[`NPC_PIN_CS5] = CS_N_IN[5];
    end
    if (~a_gio_reg[`NPC_PIN_CS4] & ~a_alt_reg[`NPC_PIN_CS4]) begin
      pa_next[`NPC_PIN_CS4] = CS_N_IN[4];
    end
  end

  // Read mux; unmapped offsets return zero.
  // Reads have no side effects, so software may poll the status freely.
  always @* begin
    case (ADDR)
      `NPC_OFF_A_DIR: rdata_next = a_dir_reg;
      `NPC_OFF_A_GIO: rdata_next = a_gio_reg;
      `NPC_OFF_A_ALT: rdata_next = a_alt_reg;
      `NPC_OFF_A_OCL: rdata_next = a_ocl_reg;
      `NPC_OFF_A_OCH: rdata_next = a_och_reg;
      `NPC_OFF_A_DAT: rdata_next = a_dat_reg;
      `NPC_OFF_B_DIR: rdata_next = b_dir_reg;
      `NPC_OFF_B_GIO: rdata_next = b_gio_reg;
      `NPC_OFF_B_OCL: rdata_next = b_ocl_reg;
      `NPC_OFF_B_OCH: rdata_next = b_och_reg;
      `NPC_OFF_B_DAT: rdata_next = b_dat_reg;
      `NPC_OFF_B_PIN: rdata_next = PB_IN;
      `NPC_OFF_FMUX: rdata_next = fmux_reg;
      `NPC_OFF_CS5H: rdata_next = cs5h_reg;
      `NPC_OFF_CS5L: rdata_next = cs5l_reg;
      // Status packs ready/busy above the chip-select five pin level.
      `NPC_OFF_STAT: rdata_next = {30'h00000000, PB_IN[`NPC_PIN_RB], PA_IN[`NPC_PIN_CS5]};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Shared pin routing. Reset leaves both mux bits set, so the SDRAM selects
  // own the pins until software hands them over to the chip selects.
  always @* begin
    if (fmux_reg[`NPC_FMUX_CS3]) begin
      cs3_next = SDRAM_SEL1_N;
    end else begin
      cs3_next = CS_N_IN[3];
    end
    if (fmux_reg[`NPC_FMUX_CS2]) begin
      cs2_next = SDRAM_SEL0_N;
    end else begin
      cs2_next = CS_N_IN[2];
    end
  end

  // Card enable terms: the chip select and ready/busy are both active low.
  assign cs5_asserted = ~CS_N_IN[5];
  assign card_busy = ~PB_IN[`NPC_PIN_RB];

  // The card must stay selected through its busy time after a page load,
  // which the controller cannot do since it releases the select per access.
  // select or busy enables
  always @* begin
    card_ce_next = ~(cs5l_reg[`NPC_CS5L_SELECT_ENABLE_BIT] & (cs5_asserted | card_busy));
  end

  // Read data stand for the one cycle after a read strobe and are zero
  // otherwise, so a stale word is never taken for an answer.
  always @(posedge CLOCK) begin
    if (RST) begin
      RDATA <= `NPC_RST_ZERO;
    end else if (RD) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= `NPC_RST_ZERO;
    end
  end

  // Registered port pins; a register write reaches the pins one edge later.
  always @(posedge CLOCK) begin
    if (RST) begin
      PA_OUT <= `NPC_RST_ZERO;
      PA_OE <= `NPC_RST_ZERO;
      PB_OUT <= `NPC_RST_ZERO;
      PB_OE <= `NPC_RST_ZERO;
    end else begin
      // latch enables from A 1 and A 2
      PA_OUT <= pa_next;
      PA_OE <= pa_oe_next;
      PB_OUT <= pb_next;
      PB_OE <= pb_oe_next;
    end
  end

  // Registered shared pins; both idle high so no memory is selected in reset.
  always @(posedge CLOCK) begin
    if (RST) begin
      CS2_PIN_N <= 1'b1;
      CS3_PIN_N <= 1'b1;
    end else begin
      CS2_PIN_N <= cs2_next;
      CS3_PIN_N <= cs3_next;
    end
  end

  // Chip-select five setup as seen by the memory controller. The fields are
  // copied unchanged, except the write strobe lane, which is decoded from the width bit; the controller turns them into strobe timing.
  always @(posedge CLOCK) begin
    if (RST) begin
      CS5_ENABLE <= 1'b0;
      CS5_WIDE <= 1'b0;
      CS5_WAIT_STATES <= 6'h00;
      CS5_RD_ASSERT <= 4'h0;
      CS5_RD_NEGATE <= 4'h0;
      CS5_BYTE_CTRL <= 1'b0;
      CS5_WR_STROBE_SEL <= 4'h0;
    end else begin
      CS5_ENABLE <= cs5l_reg[`NPC_CS5L_SELECT_ENABLE_BIT];
      CS5_WIDE <= cs5l_reg[`NPC_CS5L_WIDTH16];
      CS5_WAIT_STATES <= cs5h_reg[`NPC_CS5H_WSC_HI:`NPC_CS5H_WSC_LO];
      CS5_RD_ASSERT <= cs5l_reg[`NPC_CS5L_OEA_HI:`NPC_CS5L_OEA_LO];
      CS5_RD_NEGATE <= cs5l_reg[`NPC_CS5L_OEN_HI:`NPC_CS5L_OEN_LO];
      CS5_BYTE_CTRL <= cs5l_reg[`NPC_CS5L_EBC];
      CS5_WR_STROBE_SEL <= strobe_lane(cs5l_reg[`NPC_CS5L_WIDTH16]);
    end
  end

  // Registered card enable; the card is deselected during reset.
  always @(posedge CLOCK) begin
    if (RST) begin
      CARD_CE_N <= 1'b1;
    end else begin
      CARD_CE_N <= card_ce_next;
    end
  end

endmodule
`default_nettype wire

// file: shared/npc_defs.vh
// Register offsets, field positions and reset values for the NAND pin and chip-select setup block.
`ifndef NPC_DEFS_VH
`define NPC_DEFS_VH

// Register byte offsets, one aligned word each.
`define NPC_OFF_A_DIR 8'h00
`define NPC_OFF_A_GIO 8'h04
`define NPC_OFF_A_ALT 8'h08
`define NPC_OFF_A_OCL 8'h0C
`define NPC_OFF_A_OCH 8'h10
`define NPC_OFF_A_DAT 8'h14
`define NPC_OFF_B_DIR 8'h18
`define NPC_OFF_B_GIO 8'h1C
`define NPC_OFF_B_OCL 8'h20
`define NPC_OFF_B_OCH 8'h24
`define NPC_OFF_B_DAT 8'h28
`define NPC_OFF_B_PIN 8'h2C
`define NPC_OFF_FMUX 8'h30
`define NPC_OFF_CS5H 8'h34
`define NPC_OFF_CS5L 8'h38
`define NPC_OFF_STAT 8'h3C

// Reset values.
`define NPC_RST_ZERO 32'h00000000
`define NPC_RST_FMUX 32'h00000003

// Function mux control bits.
`define NPC_FMUX_CS2 0
`define NPC_FMUX_CS3 1

// Chip-select five fields (high word bits 45:40 sit at 13:8).
`define NPC_CS5H_WSC_HI 13
`define NPC_CS5H_WSC_LO 8
`define NPC_CS5L_OEA_HI 31
`define NPC_CS5L_OEA_LO 28
`define NPC_CS5L_OEN_HI 27
`define NPC_CS5L_OEN_LO 24
`define NPC_CS5L_EBC 11
`define NPC_CS5L_WIDTH16 8
`define NPC_CS5L_SELECT_ENABLE_BIT 0

// Pins used for the flash card.
`define NPC_PIN_CLE 1
`define NPC_PIN_ALE 2
`define NPC_PIN_CS4 22
`define NPC_PIN_CS5 23
`define NPC_PIN_RB 16

// Output-source code that selects the data register.
`define NPC_SRC_DATA 2'h3

// Write strobe lanes, one-hot: lane three for 8-bit, lane two for 16-bit.
`define NPC_LANE_8BIT 4'h8
`define NPC_LANE_16BIT 4'h4

// First pin whose output-source field sits in the high config register.
`define NPC_OCR_SPLIT 16

`endif

// file: bench/npc_pins_properties.sv
// Concurrent checks on the ports of the pin and chip-select setup block.
`timescale 1ns/1ns
`default_nettype none
module npc_pins_properties (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Pins and selects.
  input wire logic [31:0] PA_OUT,
  input wire logic [31:0] PB_IN,
  input wire logic [5:0] CS_N_IN,
  input wire logic SDRAM_SEL0_N,
  input wire logic SDRAM_SEL1_N,
  input wire logic CS2_PIN_N,
  input wire logic CS3_PIN_N,
  // Chip-select five setup and card enable.
  input wire logic CS5_ENABLE,
  input wire logic CS5_WIDE,
  input wire logic [5:0] CS5_WAIT_STATES,
  input wire logic [3:0] CS5_RD_ASSERT,
  input wire logic [3:0] CS5_RD_NEGATE,
  input wire logic CS5_BYTE_CTRL,
  input wire logic [3:0] CS5_WR_STROBE_SEL,
  input wire logic CARD_CE_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // A mux write not followed at once by another, so its effect is seen alone.
  sequence s_fmux_wr;
    WR && ADDR == 8'h30 ##1 !(WR && ADDR == 8'h30);
  endsequence
  sequence s_cs5l_wr;
    WR && ADDR == 8'h38 ##1 1'b1;
  endsequence
  // Read data stand only in the cycle after a read strobe.
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside read cycle");
  a_cs3_route: assert property (s_fmux_wr |=> CS3_PIN_N ==
    ($past(WDATA[1], 2) ? $past(SDRAM_SEL1_N) : $past(CS_N_IN[3])))
    else $error("shared pin three routed wrongly");
  a_cs2_route: assert property (s_fmux_wr |=> CS2_PIN_N ==
    ($past(WDATA[0], 2) ? $past(SDRAM_SEL0_N) : $past(CS_N_IN[2])))
    else $error("shared pin two routed wrongly");
  a_wait_count: assert property (WR && ADDR == 8'h34 |->
    ##2 CS5_WAIT_STATES == $past(WDATA[13:8], 2)) else $error("wait states wrong");
  a_rd_timing: assert property (s_cs5l_wr |=>
    {CS5_RD_ASSERT, CS5_RD_NEGATE} == $past(WDATA[31:24], 2)) else $error("read timing wrong");
  a_cs5_mode: assert property (s_cs5l_wr |=>
    {CS5_BYTE_CTRL, CS5_WIDE, CS5_ENABLE} == $past({WDATA[11], WDATA[8], WDATA[0]}, 2))
    else $error("chip select mode wrong");
  a_strobe_lane: assert property (CS5_ENABLE |->
    CS5_WR_STROBE_SEL == (CS5_WIDE ? 4'h4 : 4'h8)) else $error("write strobe lane wrong");
  a_card_select: assert property (CARD_CE_N ==
    !(CS5_ENABLE && (!$past(CS_N_IN[5]) || !$past(PB_IN[16])))) else $error("card enable wrong");
  a_latch_quiet: assert property ($rose(PA_OUT[1]) || $rose(PA_OUT[2]) |->
    $past(WR, 2)) else $error("latch enable rose without a write");
endmodule
bind npc_pins npc_pins_properties u_chk (.*);
`default_nettype wire

// file: bench/npc_card_model.sv
// Behavioural flash card: its ready/busy line for a started operation.
`timescale 1ns/1ns
`default_nettype none
module npc_card_model #(parameter int BUSY = 20) (
  // Clock, reset and operation start.
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic start,
  // Ready/busy, high when ready.
  output wire logic rb
);
  int cnt;
  // busy then ready
  // The line is driven from the count, so it reads high again once the count runs out.
  always @(posedge CLOCK) begin
    if (RST) begin
      cnt <= 0;
    end else if (start) begin
      cnt <= BUSY;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign rb = (cnt == 0);
endmodule
`default_nettype wire

// file: bench/npc_pins_tb_top.sv
// Self-checking testbench for the pin and chip-select setup block.
`timescale 1ns/1ns
`default_nettype none
`include "npc_defs.vh"
module npc_pins_tb_top;
  logic clk, rst, wr, rd, sel0_n, sel1_n, go, cs2_n, cs3_n, en, wide, bctl, ce_n;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, pa_out, pa_oe, pb_out, pb_oe;
  logic [5:0] cs_n, ws;
  logic [3:0] ra, rn, lane;
  wire logic rb;
  int n_mismatch = 0;
  int num_checks = 0;
  npc_pins DUT (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PA_IN(32'h0), .PA_OUT(pa_out), .PA_OE(pa_oe),
    .PB_IN({15'h0, rb, 16'h0}), .PB_OUT(pb_out), .PB_OE(pb_oe), .CS_N_IN(cs_n),
    .SDRAM_SEL0_N(sel0_n), .SDRAM_SEL1_N(sel1_n), .CS2_PIN_N(cs2_n), .CS3_PIN_N(cs3_n),
    .CS5_ENABLE(en), .CS5_WIDE(wide), .CS5_WAIT_STATES(ws), .CS5_RD_ASSERT(ra),
    .CS5_RD_NEGATE(rn), .CS5_BYTE_CTRL(bctl), .CS5_WR_STROBE_SEL(lane), .CARD_CE_N(ce_n));
  npc_card_model #(.BUSY(20)) card (.CLOCK(clk), .RST(rst), .start(go), .rb(rb));
  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Register effects reach the pins one edge after the register itself.
  task automatic pause;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    rreg(`NPC_OFF_FMUX, 32'h3);
    rreg(`NPC_OFF_A_DIR, 32'h0);
    rreg(8'h40, 32'h0);
    chk({ce_n, pa_out[2:1]}, 3'b100);
    $display("test reset done");
  endtask
  task automatic t_latch;
    wreg(`NPC_OFF_A_DIR, 32'h6);
    wreg(`NPC_OFF_A_GIO, 32'h6);
    wreg(`NPC_OFF_A_OCL, 32'h3C);
    wreg(`NPC_OFF_A_DAT, 32'h2);
    pause;
    chk({pa_oe[2:1], pa_out[2:1]}, 4'hD);
    wreg(`NPC_OFF_A_DAT, 32'h4);
    pause;
    chk({pa_oe[2:1], pa_out[2:1]}, 4'hE);
    $display("test latch done");
  endtask
  task automatic t_cs5;
    wreg(`NPC_OFF_CS5H, 32'hC00);
    wreg(`NPC_OFF_CS5L, 32'h14140B01);
    pause;
    chk({ws, ra, rn, bctl, wide, en, lane}, {6'hC, 8'h14, 3'b111, 4'h4});
    wreg(`NPC_OFF_CS5L, 32'h14140001);
    pause;
    chk({wide, lane}, 5'h08);
    @(posedge clk) cs_n <= 6'h1F;
    pause;
    chk(ce_n, 1'b0);
    @(posedge clk) cs_n <= 6'h3F;
    pause;
    chk(ce_n, 1'b1);
    $display("test chip select done");
  endtask
  task automatic t_rb;
    int i;
    wreg(`NPC_OFF_B_DIR, 32'h20000);
    wreg(`NPC_OFF_B_OCH, 32'hC);
    wreg(`NPC_OFF_B_DAT, 32'h20000);
    pause;
    chk(pb_oe[17:16], 2'b00);
    wreg(`NPC_OFF_B_GIO, 32'h30000);
    pause;
    chk({pb_oe[17:16], pb_out[17]}, 3'b101);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    rreg(`NPC_OFF_STAT, 32'h0);
    chk(ce_n, 1'b0);
    for (i = 0; i < 100 && rb !== 1'b1; i++) @(posedge clk);
    if (i == 100) begin
      n_mismatch++;
      report_and_stop;
    end
    rreg(`NPC_OFF_STAT, 32'h2);
    $display("test ready busy done");
  endtask
  task automatic t_pins;
    @(posedge clk) cs_n <= 6'h14;
    wreg(`NPC_OFF_A_DIR, 32'hC00006);
    pause;
    chk({pa_oe[23:22], pa_out[23:22]}, 4'hD);
    chk({cs3_n, cs2_n}, 2'b10);
    wreg(`NPC_OFF_FMUX, 32'h0);
    pause;
    chk({cs3_n, cs2_n}, 2'b01);
    $display("test shared pins done");
  endtask
  // Reset for ten cycles, then run every scenario in turn.
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    go = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    cs_n = 6'h3F;
    sel0_n = 1'b0;
    sel1_n = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_latch;
    t_cs5;
    t_rb;
    t_pins;
    report_and_stop;
  end
endmodule
`default_nettype wire
